// >>> verilog/casc_cnt_link.sv
/*
  Cascadable position counter with master/slave link.
  Holds the count, the read holding register, master election on the
  shared link, freeze of the holding register, and carry/underflow_pulse_out pulses.
  Assumes the measurement logic gives same-clock count pulses for modes
  other than count-only, and that the link wire is pulled high outside.
*/
`timescale 1ns/1ps
`default_nettype none

module casc_cnt_link (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [casc_cnt_pkg::MODE_W-1:0] mode_i,
  input wire logic count_up_i,
  input wire logic count_dn_i,
  input wire casc_cnt_pkg::bus_pins_t bus_i,
  input wire casc_cnt_pkg::cnt_pins_t cnt_pins_i,
  input wire logic master_slave_link_i,
  output logic master_slave_link_o,
  output logic master_slave_link_oe_o,
  output logic carry_n_o,
  output logic underflow_pulse_out_n_o,
  output logic [casc_cnt_pkg::BYTE_W-1:0] data_o,
  output logic data_oe_o,
  output logic is_master_o
);

  // Synchronised pins
  casc_cnt_pkg::bus_pins_t bus_s; // Bus strobes after two flops
  casc_cnt_pkg::cnt_pins_t cnt_s; // Count pins after two flops
  logic link_s; // Link level after two flops

  // State
  casc_cnt_pkg::role_t role_r; // Link role
  logic [casc_cnt_pkg::CNT_W-1:0] count_r; // Running count
  logic [casc_cnt_pkg::CNT_W-1:0] hold_r; // Read holding register
  logic rd_act_r; // Read active last cycle
  logic wr_act_r; // Write active last cycle
  logic up_n_r; // Previous up pin level
  logic down_n_r; // Previous down pin level

  // Decoded events
  logic rd_act; // Read strobe pair low
  logic wr_act; // Write strobe pair low
  logic rd_start; // First cycle of a read
  logic bus_start; // First cycle of any bus cycle
  logic pin_up; // Rising edge of up pin
  logic pin_dn; // Rising edge of down pin
  logic inc; // Count up this cycle
  logic dec; // Count down this cycle
  logic freeze; // Load holding register now
  logic [casc_cnt_pkg::CNT_W-1:0] count_nxt; // Next count

  // Sync of the bus strobes; reset level is idle
  pin_sync #(.W(4), .RST_VAL(4'hF)) u_bus_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(bus_i),
    .sync_o(bus_s)
  );

  // Sync of count pins and the link wire
  pin_sync #(.W(3), .RST_VAL(3'h7)) u_misc_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i({cnt_pins_i, master_slave_link_i}),
    .sync_o({cnt_s, link_s})
  );

  // Strobe decode and edge detection
  always_comb begin
    rd_act = !bus_s.cs_n && !bus_s.rd_n;
    wr_act = !bus_s.cs_n && !bus_s.we_n;
    rd_start = rd_act && !rd_act_r;
    bus_start = rd_start || (wr_act && !wr_act_r);
    pin_up = cnt_s.up_n && !up_n_r;
    pin_dn = cnt_s.down_n && !down_n_r;
  end

  // Count source; pins only act in count-only mode
  always_comb begin
    if (mode_i == casc_cnt_pkg::MODE_COUNT_ONLY) begin
      inc = pin_up && !pin_dn;
      dec = pin_dn && !pin_up;
    end else begin
      inc = count_up_i && !count_dn_i;
      dec = count_dn_i && !count_up_i;
    end
    if (inc) begin
      count_nxt = count_r + casc_cnt_pkg::CNT_W'(1);
    end else if (dec) begin
      count_nxt = count_r - casc_cnt_pkg::CNT_W'(1);
    end else begin
      count_nxt = count_r;
    end
  end

  // Freeze source: own low-byte read start as master or open, link low as slave
  always_comb begin
    unique case (role_r)
      casc_cnt_pkg::ROLE_MASTER: freeze = rd_start && bus_s.sel == casc_cnt_pkg::SEL_LOW;
      casc_cnt_pkg::ROLE_SLAVE: freeze = !link_s;
      casc_cnt_pkg::ROLE_OPEN: freeze = rd_start && bus_s.sel == casc_cnt_pkg::SEL_LOW;
      default: freeze = 1'b0;
    endcase
  end

  // Edge history of strobes and pins
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
      up_n_r <= 1'b1;
      down_n_r <= 1'b1;
    end else if (ce_i) begin
      rd_act_r <= rd_act;
      wr_act_r <= wr_act;
      up_n_r <= cnt_s.up_n;
      down_n_r <= cnt_s.down_n;
    end
  end

  // Role election, decided once after reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      role_r <= casc_cnt_pkg::ROLE_OPEN;
    end else if (ce_i) begin
      unique case (role_r)
        casc_cnt_pkg::ROLE_OPEN: begin
          // Link low wins over a bus cycle in the same cycle
          if (!link_s) begin
            role_r <= casc_cnt_pkg::ROLE_SLAVE;
          end else if (bus_start) begin
            role_r <= casc_cnt_pkg::ROLE_MASTER;
          end
        end
        casc_cnt_pkg::ROLE_MASTER: role_r <= casc_cnt_pkg::ROLE_MASTER;
        casc_cnt_pkg::ROLE_SLAVE: role_r <= casc_cnt_pkg::ROLE_SLAVE;
        default: role_r <= casc_cnt_pkg::ROLE_OPEN;
      endcase
    end
  end

  // Running count
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= casc_cnt_pkg::CNT_RST;
    end else if (ce_i) begin
      count_r <= count_nxt;
    end
  end

  // Holding register; a strobe that misses the sample edge just rereads it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r <= casc_cnt_pkg::CNT_RST;
    end else if (ce_i && freeze) begin
      hold_r <= count_r;
    end
  end

  // Read data and bus drive
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= casc_cnt_pkg::BYTE_RST;
      data_oe_o <= 1'b0;
    end else if (ce_i) begin
      data_oe_o <= rd_act;
      if (bus_s.sel == casc_cnt_pkg::SEL_HIGH) begin
        data_o <= hold_r[casc_cnt_pkg::CNT_W-1 -: casc_cnt_pkg::BYTE_W];
      end else if (freeze) begin
        // Fresh low byte straight from the count being latched
        data_o <= count_r[casc_cnt_pkg::BYTE_W-1:0];
      end else begin
        data_o <= hold_r[casc_cnt_pkg::BYTE_W-1:0];
      end
    end
  end

  // Link drive: master pulls the wire low one cycle per low-byte read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_slave_link_o <= 1'b0;
      master_slave_link_oe_o <= 1'b0;
      is_master_o <= 1'b0;
    end else if (ce_i) begin
      master_slave_link_o <= 1'b0; // Open drain: only ever drives low
      master_slave_link_oe_o <= (role_r == casc_cnt_pkg::ROLE_MASTER) && freeze;
      is_master_o <= role_r == casc_cnt_pkg::ROLE_MASTER;
    end
  end

  // Carry and underflow_pulse_out pulses, one cycle low, master only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_n_o <= 1'b1;
      underflow_pulse_out_n_o <= 1'b1;
    end else if (ce_i) begin
      carry_n_o <= !(role_r == casc_cnt_pkg::ROLE_MASTER && inc
                     && count_r == casc_cnt_pkg::CNT_MAX);
      underflow_pulse_out_n_o <= !(role_r == casc_cnt_pkg::ROLE_MASTER && dec
                                   && count_r == casc_cnt_pkg::CNT_RST);
    end
  end

  // Assertions
  // One clock for everything; a low enable must freeze all of it
  a_enable_freeze: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !ce_i |=> $stable(count_r) && $stable(role_r) && $stable(hold_r))
    else $error("State moved while clock enable low");

  a_slave_on_link: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && role_r == casc_cnt_pkg::ROLE_OPEN && !link_s |=> role_r == casc_cnt_pkg::ROLE_SLAVE)
    else $error("Link pulse did not make slave");

  a_master_on_bus: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && role_r == casc_cnt_pkg::ROLE_OPEN && link_s && bus_start
    |=> role_r == casc_cnt_pkg::ROLE_MASTER ##1 (is_master_o || !$past(ce_i)))
    else $error("First bus cycle did not elect master");

  a_hold_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !freeze |=> $stable(hold_r)) else $error("Holding register changed without read");

  a_pins_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && mode_i != casc_cnt_pkg::MODE_COUNT_ONLY && !count_up_i && !count_dn_i
    |=> $stable(count_r)) else $error("Count moved outside count-only mode");

  a_carry_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && role_r == casc_cnt_pkg::ROLE_MASTER && inc && count_r == casc_cnt_pkg::CNT_MAX
    |=> !carry_n_o && count_r == casc_cnt_pkg::CNT_RST) else $error("Carry missing on wrap");

  a_underflow_pulse_out_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(underflow_pulse_out_n_o) |-> $past(count_r) == casc_cnt_pkg::CNT_RST
    && count_r == casc_cnt_pkg::CNT_MAX) else $error("Underflow_pulse_out without underflow");

  // A slave never reports wraps; the master does that for the pair
  a_slave_silent: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    role_r == casc_cnt_pkg::ROLE_SLAVE |=> carry_n_o && underflow_pulse_out_n_o)
    else $error("Slave drove a wrap pulse");

endmodule // casc_cnt_link

`default_nettype wire

// >>> verilog/casc_cnt_pkg.sv
/*
  Package for the cascadable position counter link.
  Holds widths, mode codes, role states and the bus pin bundle.
  Assumes a single 100 MHz core clock shared by every user.
*/
`default_nettype none

package casc_cnt_pkg;

  // Counter, bus and mode widths
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int MODE_W = 3;

  // Mode codes used by the link logic
  localparam logic [MODE_W-1:0] MODE_COUNT_ONLY = 3'h0;
  localparam logic [MODE_W-1:0] MODE_CASC_MASTER = 3'h5;

  // Byte select codes
  localparam logic SEL_LOW = 1'h0;
  localparam logic SEL_HIGH = 1'h1;

  // Reset values and the count maximum
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  // Clock figures, in Hz
  localparam longint CLK_HZ = 100000000;
  localparam longint CLK_MAX_HZ = 20000000;

  // Synchroniser depth for pins
  localparam int SYNC_STAGES = 2;

  // Link role, one-hot
  typedef enum logic [2:0] {
    ROLE_OPEN = 3'b001,
    ROLE_MASTER = 3'b010,
    ROLE_SLAVE = 3'b100
  } role_t;

  // Bus strobes as they arrive on the pins, all active low but sel
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic we_n;
    logic sel;
  } bus_pins_t;

  // Count pins from the far counter, active low
  typedef struct packed {
    logic up_n;
    logic down_n;
  } cnt_pins_t;

endpackage : casc_cnt_pkg

`default_nettype wire

// >>> verilog/pin_sync.sv
/*
  Two-stage synchroniser for a bundle of asynchronous pins.
  Assumes the bundle's bits are independent levels; no bus coherency.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  // First stage, read only by the second stage
  logic [W-1:0] meta_r;

  // Two flops in series, frozen with the clock enable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end else if (ce_i) begin
      meta_r <= pin_i;
      sync_o <= meta_r;
    end
  end

endmodule // pin_sync

`default_nettype wire

// >>> verif/far_side_model.sv
/*
  Far side of the link: second counter's up/down pins and freeze logic.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic ref_clk_i,
  input wire logic link_oe_i,
  input wire logic link_drv_i,
  output var casc_cnt_pkg::cnt_pins_t pins_o,
  output logic link_o
);
  logic frz_r; // Freeze logic pulling the link low
  // Open-drain wire, pulled up, low while any party pulls
  assign link_o = !((link_oe_i && !link_drv_i) || frz_r);
  initial begin
    frz_r = 1'b0;
    pins_o = 2'b11;
  end
  // One low pulse, held long enough to pass the synchroniser
  task automatic step(input logic up);
    if (up) pins_o.up_n <= 1'b0;
    else pins_o.down_n <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    pins_o <= 2'b11;
    repeat (3) @(posedge ref_clk_i);
  endtask
  // Clock-synchronous freeze pulse, one cycle
  task automatic freeze();
    frz_r <= 1'b1;
    @(posedge ref_clk_i);
    frz_r <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule // far_side_model
`default_nettype wire

// >>> verif/casc_cnt_link_tb.sv
/*
  Self-checking bench for the cascadable counter link.
  Assumes the far side model and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module casc_cnt_link_tb;
  localparam casc_cnt_pkg::bus_pins_t IDLE = 4'hE; // Strobes high, sel low
  logic clk = 1'b0, rst_n = 1'b0, cup = 1'b0, cdn = 1'b0, oe_q = 1'b0, m_e = 1'b0;
  logic [2:0] mode;
  casc_cnt_pkg::bus_pins_t bus;
  casc_cnt_pkg::cnt_pins_t pins;
  logic link, link_oe, cy_n, bw_n, oe, is_m, link_drv;
  logic ce = 1'b1; // Clock enable from the bench
  int lk = 0, lk_e = 0; // Link pulses seen and expected
  logic [7:0] data;
  logic [7:0] exp_q[$]; // Expected read bytes, oldest first
  logic [15:0] cnt; // Expected count
  int err_total = 0, checked = 0, seed = 32'h5774, cy = 0, bw = 0, cy_e = 0, bw_e = 0, d;
  always #5 clk = ~clk;
  casc_cnt_link casc_cnt_link_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .mode_i(mode), .count_up_i(cup), .count_dn_i(cdn), .bus_i(bus), .cnt_pins_i(pins),
    .master_slave_link_i(link), .master_slave_link_o(link_drv),
    .master_slave_link_oe_o(link_oe),
    .carry_n_o(cy_n), .underflow_pulse_out_n_o(bw_n), .data_o(data), .data_oe_o(oe),
    .is_master_o(is_m));
  far_side_model far_side_model_inst (.ref_clk_i(clk), .link_oe_i(link_oe),
    .link_drv_i(link_drv), .pins_o(pins), .link_o(link));
  // Shared bookkeeping behind the compare tasks
  task automatic tally(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Read byte against its note
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, "read byte");
  endtask
  // Role flag against the expected role
  task automatic chk_flag(input logic got, input logic exp);
    tally(got === exp, "role flag");
  endtask
  // Pulse count against the expected count; both are bench counters
  task automatic chk_count(input int got, input int exp, input string m);
    tally(got == exp, m);
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("counts: checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watcher on the settled edge: first data_oe cycle pops the oldest note
  always @(negedge clk) begin
    oe_q <= oe;
    if (oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) tally(1'b0, "read with no note");
      else chk_byte(data, exp_q.pop_front());
    end
    // Wrap and link pulses are one cycle, so low wrap cycles and high link_oe cycles equal pulses
    if (cy_n === 1'b0) cy++;
    if (bw_n === 1'b0) bw++;
    if (link_oe === 1'b1) lk++;
  end
  // Bus read; the wait is bounded and a hang ends the run
  task automatic rd(input logic s, input logic [7:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    // An elected master pulls the link once per low-byte read
    if (m_e && !s) lk_e++;
    bus <= '{cs_n: 1'b0, rd_n: 1'b0, we_n: 1'b1, sel: s};
    while (oe !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    if (n == 12) begin
      err_total++;
      complete_run();
    end else begin
      @(posedge clk);
      bus <= IDLE;
      repeat (4) @(posedge clk);
    end
  endtask
  // Bus write, used only for election
  task automatic wr();
    bus <= '{cs_n: 1'b0, rd_n: 1'b1, we_n: 1'b0, sel: 1'b0};
    repeat (4) @(posedge clk);
    bus <= IDLE;
    repeat (4) @(posedge clk);
  endtask
  // One count step from the pins or the internal pulses, with expectation
  task automatic mv(input logic up, input logic pin);
    if (pin) far_side_model_inst.step(up);
    else begin
      if (up) cup <= 1'b1;
      else cdn <= 1'b1;
      @(posedge clk);
      cup <= 1'b0;
      cdn <= 1'b0;
      repeat (2) @(posedge clk);
    end
    // Pins count only in mode 0, pulses only outside it
    if (pin == (mode == casc_cnt_pkg::MODE_COUNT_ONLY)) begin
      if (m_e && up && cnt == 16'hFFFF) cy_e++;
      if (m_e && !up && cnt == 16'h0000) bw_e++;
      cnt = up ? cnt + 16'h0001 : cnt - 16'h0001;
    end
  endtask
  // Reset with no bus traffic until released
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    cnt = 16'h0000;
    m_e = 1'b0;
  endtask
  initial begin
    mode = casc_cnt_pkg::MODE_CASC_MASTER;
    bus = IDLE;
    do_reset();
    // First bus cycle elects master; wraps both ways
    wr();
    m_e = 1'b1;
    chk_flag(is_m, 1'b1);
    mv(1'b0, 1'b0);
    rd(1'b0, 8'hFF);
    rd(1'b1, 8'hFF);
    mv(1'b1, 1'b0);
    rd(1'b0, 8'h00);
    // Clock enable low: an internal pulse in that time must not count
    ce <= 1'b0;
    cup <= 1'b1;
    repeat (3) @(posedge clk);
    cup <= 1'b0;
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    rd(1'b0, 8'h00);
    $display("test election and wrap done");
    // Pins ignored in mode 5, counted in mode 0
    mv(1'b1, 1'b1);
    mv(1'b0, 1'b1);
    rd(1'b0, 8'h00);
    mode <= casc_cnt_pkg::MODE_COUNT_ONLY;
    @(posedge clk);
    for (int i = 0; i < 3; i++) mv(1'b1, 1'b1);
    mv(1'b0, 1'b1);
    mv(1'b1, 1'b0);
    rd(1'b0, cnt[7:0]);
    $display("test mode gating done");
    // Random walk through zero in both modes
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      mode <= d[1] ? casc_cnt_pkg::MODE_COUNT_ONLY : casc_cnt_pkg::MODE_CASC_MASTER;
      @(posedge clk);
      mv(d[0], d[1]);
    end
    rd(1'b0, cnt[7:0]);
    rd(1'b1, cnt[15:8]);
    chk_count(cy, cy_e, "carry pulses");
    chk_count(bw, bw_e, "underflow_pulse_out pulses");
    chk_count(lk, lk_e, "link pulses");
    $display("test random walk done");
    // Freeze before the first bus cycle makes a slave that never pulses
    mode <= casc_cnt_pkg::MODE_CASC_MASTER;
    do_reset();
    far_side_model_inst.freeze();
    wr();
    for (int i = 0; i < 3; i++) mv(1'b0, 1'b0);
    rd(1'b0, 8'h00);
    chk_flag(is_m, 1'b0);
    chk_count(bw, bw_e, "slave pulsed");
    chk_count(lk, lk_e, "slave drove link");
    $display("test freeze done");
    complete_run();
  end
endmodule // casc_cnt_link_tb
`default_nettype wire
